/* File: core/clsi_pkg.sv */
/*
  Shared constants and types of the charger lamp status indicator.
  Assumes one 50 MHz clock and a synchronous, active-high reset.
*/
package clsi_pkg;

  // Clock and flash timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SLOW_PERIOD_MS = 1000;
  localparam int unsigned FAST_PERIOD_MS = 250;
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / 1000 * SLOW_PERIOD_MS / 2;
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / 1000 * FAST_PERIOD_MS / 2;

  // Register offsets
  localparam logic [7:0] OVR_CTRL_OFS = 8'h10;
  localparam logic [7:0] PAT_SEL_OFS = 8'h12;
  localparam logic [7:0] ERR_LIMIT_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h16;

  // Values after reset
  localparam logic [7:0] OVR_CTRL_RST = 8'h00;
  localparam logic [7:0] PAT_SEL_RST = 8'h00;
  localparam logic [3:0] ERR_LIMIT_RST = 4'h3;

  // Field positions
  localparam int OVR_FIRST_LSB = 0;
  localparam int OVR_MODE_BIT = 3;
  localparam int OVR_SECOND_LSB = 4;
  localparam int PAT_LINK_LSB = 0;
  localparam int PAT_CHARGE_BIT = 2;
  localparam int PAT_DONE_BIT = 4;
  localparam int PAT_RESTART_BIT = 6;
  localparam int PAT_STOP_BIT = 7;
  localparam int ERR_CNT_W = 4;

  typedef enum logic [1:0] {LAMP_OFF, LAMP_SLOW, LAMP_FAST, LAMP_ON} clsi_pat_t;

  typedef enum logic [1:0] {MODE_APC, MODE_AIF, MODE_SA, MODE_HOST} clsi_mode_t;

  typedef enum logic [3:0] {
    ST_START, ST_LINK, ST_CHARGE, ST_DONE, ST_RESTART, ST_STOP,
    ST_SA_TX, ST_SA_TMO, ST_SA_PROT, ST_HOST
  } clsi_state_t;

  typedef struct packed {
    logic startDone;
    logic charging;
    logic chargeDone;
    logic protect;
    logic linkErr;
    logic txTimeout;
    logic restartDone;
  } clsi_evt_t;

  typedef struct packed {
    logic [7:0] ovrCtrl;
    logic [7:0] patSel;
    logic [ERR_CNT_W-1:0] errLimit;
  } clsi_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrStb;
    logic rdStb;
  } clsi_bus_t;

endpackage : clsi_pkg

/* File: core/clsi_flash.sv */
/*
  Free-running flash phase generator: square wave, equal halves.
  Assumes clk and a synchronous active-high rst.
*/
`timescale 1ns/1ps
`default_nettype none
module clsi_flash #(
  parameter int unsigned HALF_CYC = 4
) (
  input wire logic clk,
  input wire logic rst,
  output logic phase
);
  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_phase;

  always_comb begin
    next_cnt = cnt + 1'b1;
    next_phase = phase;
    if (cnt == LAST) begin
      next_cnt = '0;
      next_phase = !phase;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
      phase <= 1'b0;
    end else begin
      cnt <= next_cnt;
      phase <= next_phase;
    end
  end

  a_half_toggle: assert property (@(posedge clk) disable iff (rst)
    (cnt == LAST) |=> (phase != $past(phase)))
    else $error("flash phase did not toggle at half period");

  a_half_steady: assert property (@(posedge clk) disable iff (rst)
    (cnt != LAST) |=> $stable(phase))
    else $error("flash phase toggled early");
endmodule : clsi_flash
`default_nettype wire

/* File: core/clsi_regs.sv */
/*
  Register file behind the plain strobe port.
  Assumes strobes are one cycle long and never together.
*/
`timescale 1ns/1ps
`default_nettype none
module clsi_regs (
  input wire logic clk,
  input wire logic rst,
  input wire clsi_pkg::clsi_bus_t bus,
  input wire logic [7:0] statusByte,
  output clsi_pkg::clsi_cfg_t cfg,
  output logic [7:0] rdData
);
  clsi_pkg::clsi_cfg_t next_cfg;
  logic [7:0] next_rdData;

  always_comb begin
    next_cfg = cfg;
    if (bus.wrStb) begin
      case (bus.addr)
        clsi_pkg::OVR_CTRL_OFS: next_cfg.ovrCtrl = bus.wrData;
        clsi_pkg::PAT_SEL_OFS: next_cfg.patSel = bus.wrData;
        clsi_pkg::ERR_LIMIT_OFS: next_cfg.errLimit = bus.wrData[clsi_pkg::ERR_CNT_W-1:0];
        default: next_cfg = cfg;
      endcase
    end
  end

  // Read data lives one cycle only; zero otherwise and for unmapped offsets
  always_comb begin
    next_rdData = 8'h00;
    if (bus.rdStb) begin
      case (bus.addr)
        clsi_pkg::OVR_CTRL_OFS: next_rdData = cfg.ovrCtrl;
        clsi_pkg::PAT_SEL_OFS: next_rdData = cfg.patSel;
        clsi_pkg::ERR_LIMIT_OFS: next_rdData = {4'h0, cfg.errLimit};
        clsi_pkg::STATUS_OFS: next_rdData = statusByte;
        default: next_rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg.ovrCtrl <= clsi_pkg::OVR_CTRL_RST;
      cfg.patSel <= clsi_pkg::PAT_SEL_RST;
      cfg.errLimit <= clsi_pkg::ERR_LIMIT_RST;
      rdData <= 8'h00;
    end else begin
      cfg <= next_cfg;
      rdData <= next_rdData;
    end
  end
endmodule : clsi_regs
`default_nettype wire

/* File: core/clsi_top.sv */
/*
  Lamp status controller of a wireless power transmitter: status sequencer,
  error counting and two flashing lamps plus an interrupt lamp.
  Assumes status events come from logic on the same clock, one cycle wide except charging, which is held as a level.
*/
`timescale 1ns/1ps
`default_nettype none
module clsi_top #(
  parameter int unsigned SLOW_HALF = clsi_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = clsi_pkg::FAST_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire clsi_pkg::clsi_bus_t bus,
  output logic [7:0] rdData,
  input wire clsi_pkg::clsi_mode_t modeSel,
  input wire clsi_pkg::clsi_evt_t evt,
  input wire logic txIrqN,
  output logic firstLamp,
  output logic secondLamp,
  output logic irqLamp,
  output logic powerStopped
);

  clsi_pkg::clsi_cfg_t cfg;
  clsi_pkg::clsi_state_t state;
  clsi_pkg::clsi_state_t next_state;
  logic [clsi_pkg::ERR_CNT_W-1:0] errCnt;
  logic [clsi_pkg::ERR_CNT_W-1:0] next_errCnt;
  logic next_firstLamp;
  logic next_secondLamp;
  logic slowPhase;
  logic fastPhase;
  logic errEvt;
  logic limitHit;
  logic ovrMode;
  clsi_pkg::clsi_pat_t patFirst;
  clsi_pkg::clsi_pat_t patSecond;
  logic [7:0] statusByte;

  // Lamp level for a pattern at the current flash phases
  function automatic logic lamp_drive(
    input clsi_pkg::clsi_pat_t pat,
    input logic slow,
    input logic fast
  );
    case (pat)
      clsi_pkg::LAMP_SLOW: lamp_drive = slow;
      clsi_pkg::LAMP_FAST: lamp_drive = fast;
      clsi_pkg::LAMP_ON: lamp_drive = 1'b1;
      default: lamp_drive = 1'b0;
    endcase
  endfunction : lamp_drive

  // Error count after one more event, saturating
  function automatic logic [clsi_pkg::ERR_CNT_W-1:0] count_up(
    input logic [clsi_pkg::ERR_CNT_W-1:0] cnt
  );
    count_up = (&cnt) ? cnt : cnt + 1'b1;
  endfunction : count_up

  clsi_regs u_regs (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .statusByte(statusByte),
    .cfg(cfg),
    .rdData(rdData)
  );

  clsi_flash #(.HALF_CYC(SLOW_HALF)) u_slow (
    .clk(clk),
    .rst(rst),
    .phase(slowPhase)
  );

  clsi_flash #(.HALF_CYC(FAST_HALF)) u_fast (
    .clk(clk),
    .rst(rst),
    .phase(fastPhase)
  );

  assign errEvt = evt.protect | evt.linkErr;
  // Widened compare so a saturated count still meets any limit
  assign limitHit = ({1'b0, errCnt} + 5'h01) >= {1'b0, cfg.errLimit};
  assign ovrMode = cfg.ovrCtrl[clsi_pkg::OVR_MODE_BIT];
  assign powerStopped = (state == clsi_pkg::ST_STOP);
  assign statusByte = {powerStopped, state == clsi_pkg::ST_RESTART, 2'h0, errCnt};

  // Straight from the interrupt pin level; no register, so no lag
  assign irqLamp = !txIrqN;

  // Operating status sequencer
  always_comb begin
    next_state = state;
    next_errCnt = errCnt;
    case (state)
      clsi_pkg::ST_START: begin
        if (evt.startDone) begin
          case (modeSel)
            clsi_pkg::MODE_SA: next_state = clsi_pkg::ST_SA_TX;
            clsi_pkg::MODE_HOST: next_state = clsi_pkg::ST_HOST;
            default: next_state = clsi_pkg::ST_LINK;
          endcase
        end
      end
      clsi_pkg::ST_LINK, clsi_pkg::ST_CHARGE, clsi_pkg::ST_DONE: begin
        if (errEvt) begin
          next_errCnt = count_up(errCnt);
          // Limit checked on the event that reaches it, not one later
          next_state = limitHit ? clsi_pkg::ST_STOP : clsi_pkg::ST_RESTART;
        end else if (state == clsi_pkg::ST_LINK && evt.charging) begin
          next_state = clsi_pkg::ST_CHARGE;
        end else if (state == clsi_pkg::ST_CHARGE && evt.chargeDone) begin
          next_state = clsi_pkg::ST_DONE;
        end else if (state == clsi_pkg::ST_CHARGE && !evt.charging) begin
          next_state = clsi_pkg::ST_LINK;
        end else if (state == clsi_pkg::ST_DONE && evt.charging) begin
          next_state = clsi_pkg::ST_CHARGE;
        end
      end
      clsi_pkg::ST_RESTART: begin
        if (evt.restartDone) begin
          next_state = clsi_pkg::ST_LINK;
        end
      end
      clsi_pkg::ST_STOP: begin
        // Only a reset brings power back
        next_state = clsi_pkg::ST_STOP;
      end
      clsi_pkg::ST_SA_TX: begin
        if (evt.protect) begin
          next_state = clsi_pkg::ST_SA_PROT;
        end else if (evt.txTimeout) begin
          next_state = clsi_pkg::ST_SA_TMO;
        end
      end
      clsi_pkg::ST_SA_TMO, clsi_pkg::ST_SA_PROT, clsi_pkg::ST_HOST: begin
        next_state = state;
      end
      default: begin
        next_state = clsi_pkg::ST_START;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= clsi_pkg::ST_START;
      errCnt <= '0;
    end else begin
      state <= next_state;
      errCnt <= next_errCnt;
    end
  end

  // Pattern choice per status, or per override field
  always_comb begin
    patFirst = clsi_pkg::LAMP_OFF;
    patSecond = clsi_pkg::LAMP_OFF;
    if (ovrMode) begin
      patFirst = clsi_pkg::clsi_pat_t'(cfg.ovrCtrl[clsi_pkg::OVR_FIRST_LSB +: 2]);
      patSecond = clsi_pkg::clsi_pat_t'(cfg.ovrCtrl[clsi_pkg::OVR_SECOND_LSB +: 2]);
    end else begin
      // Override fields unread here; host state falls to dark
      case (state)
        clsi_pkg::ST_LINK: begin
          case (cfg.patSel[clsi_pkg::PAT_LINK_LSB +: 2])
            2'h0: patFirst = clsi_pkg::LAMP_FAST;
            2'h1: patSecond = clsi_pkg::LAMP_FAST;
            2'h2: patFirst = clsi_pkg::LAMP_ON;
            default: patSecond = clsi_pkg::LAMP_ON;
          endcase
        end
        clsi_pkg::ST_CHARGE: begin
          if (cfg.patSel[clsi_pkg::PAT_CHARGE_BIT]) begin
            patSecond = clsi_pkg::LAMP_ON;
          end else begin
            patFirst = clsi_pkg::LAMP_ON;
          end
        end
        clsi_pkg::ST_DONE: begin
          if (cfg.patSel[clsi_pkg::PAT_DONE_BIT]) begin
            patSecond = clsi_pkg::LAMP_ON;
          end
        end
        clsi_pkg::ST_RESTART: begin
          if (!cfg.patSel[clsi_pkg::PAT_RESTART_BIT]) begin
            patFirst = clsi_pkg::LAMP_SLOW;
          end
        end
        clsi_pkg::ST_STOP: begin
          if (!cfg.patSel[clsi_pkg::PAT_STOP_BIT]) begin
            patFirst = clsi_pkg::LAMP_SLOW;
          end
        end
        clsi_pkg::ST_SA_TX: begin
          patFirst = clsi_pkg::LAMP_ON;
        end
        clsi_pkg::ST_SA_PROT: begin
          patFirst = clsi_pkg::LAMP_SLOW;
        end
        default: begin
          // Start-up, timeout and host without override stay dark
          patFirst = clsi_pkg::LAMP_OFF;
        end
      endcase
    end
    next_firstLamp = lamp_drive(patFirst, slowPhase, fastPhase);
    next_secondLamp = lamp_drive(patSecond, slowPhase, fastPhase);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      firstLamp <= 1'b0;
      secondLamp <= 1'b0;
    end else begin
      firstLamp <= next_firstLamp;
      secondLamp <= next_secondLamp;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_irq_lamp_level: assert property (
    irqLamp == !txIrqN)
    else $error("interrupt lamp differs from interrupt level");

  a_error_restart: assert property (
    (state inside {clsi_pkg::ST_LINK, clsi_pkg::ST_CHARGE, clsi_pkg::ST_DONE})
      && errEvt && !limitHit
    |=> state == clsi_pkg::ST_RESTART && errCnt == $past(errCnt) + 1'b1)
    else $error("error did not lead to restart");

  a_limit_stop: assert property (
    (state inside {clsi_pkg::ST_LINK, clsi_pkg::ST_CHARGE, clsi_pkg::ST_DONE})
      && errEvt && limitHit
    |=> powerStopped ##1 powerStopped)
    else $error("error limit did not stop power");

  a_start_dark: assert property (
    state == clsi_pkg::ST_START && !ovrMode |=> !firstLamp && !secondLamp)
    else $error("lamps lit during start-up");

  a_link_pattern: assert property (
    state == clsi_pkg::ST_LINK && !ovrMode && cfg.patSel[1:0] == 2'h3
    |=> !firstLamp && secondLamp)
    else $error("link steady pattern wrong");

  a_charge_lamp: assert property (
    state == clsi_pkg::ST_CHARGE && !ovrMode
    |=> firstLamp == !$past(cfg.patSel[clsi_pkg::PAT_CHARGE_BIT])
      && secondLamp == $past(cfg.patSel[clsi_pkg::PAT_CHARGE_BIT]))
    else $error("charging lamp choice wrong");

  a_restart_dark: assert property (
    state == clsi_pkg::ST_RESTART && !ovrMode && cfg.patSel[clsi_pkg::PAT_RESTART_BIT]
    |=> !firstLamp && !secondLamp)
    else $error("restart lamps not dark");

  a_host_dark: assert property (
    state == clsi_pkg::ST_HOST && !ovrMode |=> !firstLamp && !secondLamp)
    else $error("host mode lit without override");

  a_override_field: assert property (
    ovrMode && cfg.ovrCtrl[1:0] == 2'h3 && cfg.ovrCtrl[5:4] == 2'h0
    |=> firstLamp && !secondLamp)
    else $error("override fields not followed");

  a_sa_transmit: assert property (
    state == clsi_pkg::ST_SA_TX && !ovrMode |=> firstLamp && !secondLamp)
    else $error("stand-alone transmit lamp wrong");

  a_link_fast_first: assert property (
    state == clsi_pkg::ST_LINK && !ovrMode && cfg.patSel[1:0] == 2'h0
    |=> firstLamp == $past(fastPhase) && !secondLamp)
    else $error("link fast flash on first lamp wrong");

  a_link_fast_second: assert property (
    state == clsi_pkg::ST_LINK && !ovrMode && cfg.patSel[1:0] == 2'h1
    |=> !firstLamp && secondLamp == $past(fastPhase))
    else $error("link fast flash on second lamp wrong");

  a_link_steady_first: assert property (
    state == clsi_pkg::ST_LINK && !ovrMode && cfg.patSel[1:0] == 2'h2
    |=> firstLamp && !secondLamp)
    else $error("link steady first lamp wrong");

  a_done_lamp: assert property (
    state == clsi_pkg::ST_DONE && !ovrMode
    |=> !firstLamp && secondLamp == $past(cfg.patSel[clsi_pkg::PAT_DONE_BIT]))
    else $error("completion lamp choice wrong");

  a_restart_flash: assert property (
    state == clsi_pkg::ST_RESTART && !ovrMode && !cfg.patSel[clsi_pkg::PAT_RESTART_BIT]
    |=> firstLamp == $past(slowPhase) && !secondLamp)
    else $error("restart slow flash wrong");

  a_stop_lamp: assert property (
    state == clsi_pkg::ST_STOP && !ovrMode
    |=> firstLamp == ($past(slowPhase) && !$past(cfg.patSel[clsi_pkg::PAT_STOP_BIT]))
      && !secondLamp)
    else $error("stopped lamp pattern wrong");

  // Stopped is final; only the reset, which disables this, may leave it
  a_stop_final: assert property (
    powerStopped |=> powerStopped)
    else $error("stopped status was left");

  a_error_ignored: assert property (
    !(state inside {clsi_pkg::ST_LINK, clsi_pkg::ST_CHARGE, clsi_pkg::ST_DONE})
    |=> $stable(errCnt))
    else $error("error counted outside link states");

  a_restart_return: assert property (
    state == clsi_pkg::ST_RESTART && evt.restartDone |=> state == clsi_pkg::ST_LINK)
    else $error("restart did not return to link");

  a_sa_protect: assert property (
    state == clsi_pkg::ST_SA_PROT && !ovrMode
    |=> firstLamp == $past(slowPhase) && !secondLamp)
    else $error("stand-alone protection flash wrong");

  a_sa_timeout_dark: assert property (
    state == clsi_pkg::ST_SA_TMO && !ovrMode |=> !firstLamp && !secondLamp)
    else $error("stand-alone timeout lamps not dark");

  a_override_slow: assert property (
    ovrMode && cfg.ovrCtrl[1:0] == 2'h1 |=> firstLamp == $past(slowPhase))
    else $error("first override slow flash wrong");

  a_override_fast: assert property (
    ovrMode && cfg.ovrCtrl[5:4] == 2'h2 |=> secondLamp == $past(fastPhase))
    else $error("second override fast flash wrong");

endmodule : clsi_top
`default_nettype wire

/* File: testbench/clsi_lamp_board.sv */
/*
  Board lamp model: counts lit cycles and level changes of each lamp.
  Assumes lamps are sampled on the design clock; clear opens a window.
*/
`timescale 1ns/1ps
`default_nettype none
module clsi_lamp_board (
  input wire logic clk,
  input wire logic clear,
  input wire logic firstLamp,
  input wire logic secondLamp,
  output logic [4:0] litFirst,
  output logic [4:0] litSecond,
  output logic [4:0] edgesFirst,
  output logic [4:0] edgesSecond
);
  logic lastFirst;
  logic lastSecond;

  // A lamp keeps nothing but its level; counts keep adding, wrapping at 32, until the next clear
  always @(posedge clk) begin
    if (clear) begin
      litFirst <= 5'h00;
      litSecond <= 5'h00;
      edgesFirst <= 5'h00;
      edgesSecond <= 5'h00;
    end else begin
      litFirst <= litFirst + 5'(firstLamp);
      litSecond <= litSecond + 5'(secondLamp);
      edgesFirst <= edgesFirst + 5'(firstLamp != lastFirst);
      edgesSecond <= edgesSecond + 5'(secondLamp != lastSecond);
    end
    lastFirst <= firstLamp;
    lastSecond <= secondLamp;
  end
endmodule : clsi_lamp_board
`default_nettype wire

/* File: testbench/charger_led_status_indicator_test.sv */
/*
  Self-checking bench of the lamp status controller with short flash periods.
  Assumes clsi_pkg, clsi_top and the board lamp model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module charger_led_status_indicator_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  clsi_pkg::clsi_bus_t bus = '0;
  clsi_pkg::clsi_mode_t modeSel = clsi_pkg::MODE_APC;
  clsi_pkg::clsi_evt_t evt = '0;
  logic txIrqN = 1'b1;
  logic clear = 1'b0;
  logic [7:0] rdData;
  logic firstLamp, secondLamp, irqLamp, powerStopped;
  logic [4:0] litFirst, litSecond, edgesFirst, edgesSecond;
  int seed = 43577;
  int numErrors = 0;
  int testsRun = 0;
  logic [7:0] pat;
  logic [7:0] got;

  always #10 clk = ~clk;

  // Short halves keep each 16-cycle window an exact number of periods
  clsi_top #(.SLOW_HALF(4), .FAST_HALF(2)) uut (.clk(clk), .rst(rst), .bus(bus),
    .rdData(rdData), .modeSel(modeSel), .evt(evt), .txIrqN(txIrqN), .firstLamp(firstLamp),
    .secondLamp(secondLamp), .irqLamp(irqLamp), .powerStopped(powerStopped));

  clsi_lamp_board board (.clk(clk), .clear(clear), .firstLamp(firstLamp),
    .secondLamp(secondLamp), .litFirst(litFirst), .litSecond(litSecond),
    .edgesFirst(edgesFirst), .edgesSecond(edgesSecond));

  task automatic stopTest();
    $display("Checks run %0d, mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stopTest

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    testsRun++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      numErrors++;
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
    @(posedge clk);
    bus.wrStb <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
    @(posedge clk);
    bus.rdStb <= 1'b0;
    #1 d = rdData;
  endtask : rd

  task automatic pulse(input logic [6:0] m);
    @(posedge clk);
    evt <= evt | m;
    @(posedge clk);
    evt <= evt & ~m;
  endtask : pulse

  task automatic doReset(input clsi_pkg::clsi_mode_t m);
    @(posedge clk);
    rst <= 1'b1;
    modeSel <= m;
    evt <= '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : doReset

  // Codes as clsi_pat_t: 0 off, 1 slow, 2 fast, 3 on; 4 is no valid pattern
  function automatic logic [2:0] cls(input logic [4:0] lit, input logic [4:0] edges);
    if (lit == 5'h00) return 3'h0;
    if (lit == 5'h10) return 3'h3;
    if (lit != 5'h08) return 3'h4;
    return (edges == 5'h04) ? 3'h1 : (edges == 5'h08) ? 3'h2 : 3'h4;
  endfunction : cls

  // States: 0 dark, 1 link, 2 charge, 3 done, 4 restart, 5 stopped
  function automatic logic [3:0] expLamps(input int st, input logic [7:0] p);
    case (st)
      1: return (p[1:0] == 2'h0) ? 4'h8 : (p[1:0] == 2'h1) ? 4'h2 : (p[1:0] == 2'h2) ? 4'hC : 4'h3;
      2: return p[2] ? 4'h3 : 4'hC;
      3: return p[4] ? 4'h3 : 4'h0;
      4: return p[6] ? 4'h0 : 4'h4;
      5: return p[7] ? 4'h0 : 4'h4;
      default: return 4'h0;
    endcase
  endfunction : expLamps

  task automatic lampChk(input logic [3:0] exp);
    repeat (3) @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    repeat (16) @(posedge clk);
    #1;
    check("firstLamp", {6'h00, exp[3:2]}, {5'h00, cls(litFirst, edgesFirst)});
    check("secondLamp", {6'h00, exp[1:0]}, {5'h00, cls(litSecond, edgesSecond)});
  endtask : lampChk

  task automatic autoState(input int st);
    for (int i = 0; i < 4; i++) begin
      pat = 8'($random(seed));
      pat[1:0] = 2'(i);
      {pat[7], pat[6], pat[4], pat[2]} = {4{i[0]}};
      wr(8'h12, pat);
      lampChk(expLamps(st, pat));
    end
    rd(8'h12, got);
    check("patSel", pat, got);
  endtask : autoState

  task automatic ovrChk();
    logic [7:0] ovr;
    for (int i = 0; i < 4; i++) begin
      ovr = 8'($random(seed));
      ovr[3] = 1'b1;
      ovr[1:0] = 2'(i);
      ovr[5:4] = 2'(3 - i);
      wr(8'h10, ovr);
      lampChk({ovr[1:0], ovr[5:4]});
    end
    ovr[3] = 1'b0;
    wr(8'h10, ovr);
    lampChk(4'h0);
    rd(8'h10, got);
    check("ovrCtrl", ovr, got);
  endtask : ovrChk

  task automatic irqChk();
    repeat (8) begin
      @(posedge clk);
      txIrqN <= 1'($random(seed));
      #1 check("irqLamp", {7'h00, ~txIrqN}, {7'h00, irqLamp});
    end
  endtask : irqChk

  initial begin
    // Auto run; reset leaves the override bit clear as auto modes need
    doReset(clsi_pkg::clsi_mode_t'({1'b0, 1'($random(seed))}));
    rd(8'h10, got);
    check("ovrReset", 8'h00, got);
    rd(8'h12, got);
    check("patReset", 8'h00, got);
    wr(8'h16, 8'hFF);
    rd(8'h16, got);
    check("statusRo", 8'h00, got);
    rd(8'h20, got);
    check("unmapped", 8'h00, got);
    wr(8'h14, 8'hF3);
    rd(8'h14, got);
    check("errLimit", 8'h03, got);
    lampChk(4'h0);
    pulse(7'h40);
    autoState(1);
    @(posedge clk);
    evt <= 7'h20;
    autoState(2);
    @(posedge clk);
    evt <= 7'h30;
    @(posedge clk);
    evt <= 7'h00;
    autoState(3);
    irqChk();
    pulse(7'h04);
    rd(8'h16, got);
    check("status", 8'h41, got);
    autoState(4);
    pulse(7'h01);
    pulse(7'h08);
    rd(8'h16, got);
    check("status", 8'h42, got);
    check("powerStopped", 8'h00, {7'h00, powerStopped});
    pulse(7'h01);
    pulse(7'h04);
    rd(8'h16, got);
    check("stopped", 8'h80, got & 8'hC0);
    check("powerStopped", 8'h01, {7'h00, powerStopped});
    autoState(5);
    pulse(7'h04);
    rd(8'h16, got);
    check("stayStopped", 8'h80, got & 8'hC0);
    // Stand-alone: protection stays final through a later timeout; timeout alone goes dark
    doReset(clsi_pkg::MODE_SA);
    pulse(7'h40);
    lampChk(4'hC);
    pulse(7'h08);
    lampChk(4'h4);
    pulse(7'h02);
    lampChk(4'h4);
    doReset(clsi_pkg::MODE_SA);
    pulse(7'h40);
    pulse(7'h02);
    lampChk(4'h0);
    doReset(clsi_pkg::MODE_HOST);
    pulse(7'h40);
    ovrChk();
    irqChk();
    stopTest();
  end

  initial begin
    #(20 * 30000);
    numErrors++;
    stopTest();
  end
endmodule : charger_led_status_indicator_test
`default_nettype wire
